// File: include/canrx_consts.vh
// Constants of the CAN receive filter and queue block.
// Included by canrx_filter_fifo under hw/ and by the dv/ checks and bench; definitions only.
`ifndef CANRX_CONSTS_VH
`define CANRX_CONSTS_VH

// Register byte offsets on the APB bus.
`define CANRX_OFS_CTL 12'h000
`define CANRX_OFS_QCS0 12'h004
`define CANRX_OFS_QCS1 12'h008
`define CANRX_OFS_FSCALE 12'h010
`define CANRX_OFS_FLIST 12'h014
`define CANRX_OFS_FASSOC 12'h018
`define CANRX_OFS_FACT 12'h01C
`define CANRX_OFS_Q0BASE 12'h020
`define CANRX_OFS_Q1BASE 12'h030
`define CANRX_OFS_FBASE 12'h100

// Field positions.
`define CANRX_CTL_DROP 0
`define CANRX_QCS_LVL_HI 1
`define CANRX_QCS_FULL 3
`define CANRX_QCS_OVR 4
`define CANRX_QCS_REL 5
`define CANRX_PROP_FDF 4
`define CANRX_PROP_IDX_LO 8

// Reset values.
`define CANRX_RST_WORD 32'h00000000
`define CANRX_RST_BANKS 28'h0000000
`define CANRX_RST_MAP 8'hE4

// Queue depth, bank count and frame storage layout.
`define CANRX_QDEPTH 2'h3
`define CANRX_NBANK 28
`define CANRX_DATA_WORDS 5'h10
`define CANRX_W_ID 5'h00
`define CANRX_W_PROP 5'h01
`define CANRX_W_DATA 5'h02
`define CANRX_W_DATA1 5'h03

// Bit 0 of a 32-bit filter word is reserved and never compared.
`define CANRX_ID_MASK 32'hFFFFFFFE

`endif

// File: hw/canrx_frame_mem.v
// Frame storage for both receive queues: one write port, one read port.
// Assumes a single clock; read data appear one edge after the address.
`timescale 1ns/100ps

module canrx_frame_mem #(
   parameter AW = 8,
   parameter DW = 32
)
(
   // Clock.
   input wire clk_sys,
   // Write port.
   input wire memWe,
   input wire [AW-1:0] memWaddr,
   input wire [DW-1:0] memWdata,
   // Read port.
   input wire [AW-1:0] memRaddr,
   output reg [DW-1:0] memRdata
);

   reg [DW-1:0] store [0:(1<<AW)-1];

   ////////////////////////////////////////////////////////////////////////////
   // No reset on the array: the queue only shows slots that a finished frame has filled,
   // but data reads past that frame's last word return whatever the slot held before.
   always @(posedge clk_sys)
   begin
      if (memWe)
      begin
         store[memWaddr] <= memWdata;
      end
      memRdata <= store[memRaddr];
   end

endmodule

// File: hw/canrx_filter_fifo.v
// Receive path of a CAN controller: acceptance filter banks, two frame
// queues and the APB register file through which software drains them.
// Assumes a bit engine that delivers frame headers, data words and a
// completion or error strobe, all synchronous to clk_sys.
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/100ps
`include "canrx_consts.vh"

module canrx_filter_fifo #(
   parameter NBANK = `CANRX_NBANK
)
(
   // Clock and reset.
   input wire clk_sys,
   input wire rstn,
   // APB slave.
   input wire [11:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Frame stream from the bit engine.
   input wire rxStart,
   input wire [10:0] rxStdId,
   input wire [17:0] rxExtId,
   input wire rxExtFmt,
   input wire rxRemote,
   input wire rxFd,
   input wire [3:0] rxDlc,
   input wire rxWordValid,
   input wire [31:0] rxWord,
   input wire rxDone,
   input wire rxError
);

   ////////////////////////////////////////////////////////////////////////////
   // Helper functions.

   // Filter numbers a bank contributes.
   function [2:0] subCount;
      input sc32;
      input lst;
      begin
         subCount = sc32 ? (lst ? 3'd2 : 3'd1) : (lst ? 3'd4 : 3'd2);
      end
   endfunction

   // Match of sub-filter k of one bank against the frame identifier.
   function subHit;
      input [31:0] id32;
      input [15:0] id16;
      input [31:0] w0;
      input [31:0] w1;
      input sc32;
      input lst;
      input [1:0] k;
      reg [31:0] v;
      reg [31:0] m;
      reg [31:0] word;
      reg [15:0] h;
      reg [15:0] hm;
      begin
         v = k[0] ? w1 : w0;
         m = lst ? `CANRX_ID_MASK : w1 & `CANRX_ID_MASK;
         if (lst)
         begin
            word = k[1] ? w1 : w0;
            h = k[0] ? word[31:16] : word[15:0];
            hm = 16'hFFFF;
         end
         else
         begin
            word = k[0] ? w1 : w0;
            h = word[15:0];
            hm = word[31:16];
         end
         if (sc32)
            subHit = ((id32 ^ v) & m) == 32'h00000000;
         else
            subHit = ((id16 ^ h) & hm) == 16'h0000;
      end
   endfunction

   // Drop the oldest entry and move the others forward; spare is kept.
   function [7:0] mapRelease;
      input [7:0] map;
      begin
         mapRelease = {map[7:6], map[1:0], map[5:4], map[3:2]};
      end
   endfunction

   // Swap the spare slot into queue position p.
   function [7:0] mapCommit;
      input [7:0] map;
      input [1:0] p;
      begin
         case (p)
            2'd0: mapCommit = {map[1:0], map[5:2], map[7:6]};
            2'd1: mapCommit = {map[3:2], map[5:4], map[7:6], map[1:0]};
            default: mapCommit = {map[5:4], map[7:6], map[3:0]};
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Configuration and queue state.

   reg [31:0] ctl_reg;
   reg [NBANK-1:0] fScale_reg;
   reg [NBANK-1:0] fList_reg;
   reg [NBANK-1:0] fAssoc_reg;
   reg [NBANK-1:0] fAct_reg;
   reg [31:0] fWord0_reg [0:NBANK-1];
   reg [31:0] fWord1_reg [0:NBANK-1];
   // Per queue: positions 0..2 in age order plus one spare slot (bits 7:6).
   reg [7:0] map_reg [0:1];
   reg [7:0] map_next [0:1];
   reg [1:0] lvl_reg [0:1];
   reg [1:0] lvl_next [0:1];
   reg ovr_reg [0:1];
   reg ovr_next [0:1];
   reg [3:0] rdPtr_reg [0:1];
   reg [3:0] rdPtr_next [0:1];
   // Frame being received.
   reg stgOn_reg;
   reg stgQ_reg;
   reg [7:0] stgIdx_reg;
   reg [3:0] stgDlc_reg;
   reg stgFd_reg;
   reg [4:0] stgWord_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Acceptance filter.

   wire [31:0] id32 = {rxStdId, rxExtId, rxExtFmt, rxRemote, 1'b0};
   wire [15:0] id16 = {rxStdId, rxRemote, rxExtFmt, rxExtId[17:15]};
   reg hitAny;
   reg hitQ;
   reg [7:0] hitNum;
   reg [9:0] bestKey;
   reg [9:0] key;
   reg [7:0] base0;
   reg [7:0] base1;
   reg [7:0] num;
   reg [2:0] cnt;
   reg [2:0] kk;
   integer b;

   always @*
   begin
      hitAny = 1'b0;
      hitQ = 1'b0;
      hitNum = 8'h00;
      bestKey = 10'h3FF;
      key = 10'h3FF;
      base0 = 8'h00;
      base1 = 8'h00;
      num = 8'h00;
      cnt = 3'd0;
      for (b = 0; b < NBANK; b = b + 1)
      begin
         cnt = subCount(fScale_reg[b], fList_reg[b]);
         for (kk = 3'd0; kk < 3'd4; kk = kk + 3'd1)
         begin
            num = (fAssoc_reg[b] ? base1 : base0) + {5'h00, kk};
            key = {~fScale_reg[b], ~fList_reg[b], num};
            if (kk < cnt && fAct_reg[b]
                && subHit(id32, id16, fWord0_reg[b], fWord1_reg[b],
                          fScale_reg[b], fList_reg[b], kk[1:0])
                && key < bestKey)
            begin
               bestKey = key;
               hitAny = 1'b1;
               hitQ = fAssoc_reg[b];
               hitNum = num;
            end
         end
         // Inactive banks still use up their numbers.
         if (fAssoc_reg[b])
            base1 = base1 + {5'h00, cnt};
         else
            base0 = base0 + {5'h00, cnt};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB decode.

   wire apbAccess = psel & penable;
   wire apbDone = apbAccess & pready;
   wire apbWr = apbDone & pwrite;
   wire qReg = paddr[11:5] == 7'h01 && paddr[1:0] == 2'b00;
   wire qSel = paddr[4];
   wire [1:0] qWord = paddr[3:2];
   wire fReg = paddr[11:8] == 4'h1 && paddr[7:3] < NBANK && paddr[1:0] == 2'b00;
   wire [4:0] fBank = paddr[7:3];
   wire [7:0] selMap = map_reg[qSel];
   wire [31:0] memRdata;
   reg [4:0] rdWord;
   reg [31:0] rdVal;
   reg mapped;

   always @*
   begin
      case (qWord)
         2'd0: rdWord = `CANRX_W_ID;
         2'd1: rdWord = `CANRX_W_PROP;
         2'd2: rdWord = `CANRX_W_DATA + {1'b0, rdPtr_reg[qSel]};
         default: rdWord = `CANRX_W_DATA1;
      endcase
   end

   always @*
   begin
      rdVal = `CANRX_RST_WORD;
      mapped = 1'b1;
      if (qReg)
         rdVal = (lvl_reg[qSel] != 2'd0) ? memRdata : `CANRX_RST_WORD;
      else if (fReg)
         rdVal = paddr[2] ? fWord1_reg[fBank] : fWord0_reg[fBank];
      else
      begin
         case (paddr)
            `CANRX_OFS_CTL: rdVal = ctl_reg;
            `CANRX_OFS_QCS0, `CANRX_OFS_QCS1:
            begin
               rdVal[`CANRX_QCS_LVL_HI:0] = lvl_reg[paddr[3]];
               rdVal[`CANRX_QCS_FULL] = lvl_reg[paddr[3]] == `CANRX_QDEPTH;
               rdVal[`CANRX_QCS_OVR] = ovr_reg[paddr[3]];
            end
            `CANRX_OFS_FSCALE: rdVal[NBANK-1:0] = fScale_reg;
            `CANRX_OFS_FLIST: rdVal[NBANK-1:0] = fList_reg;
            `CANRX_OFS_FASSOC: rdVal[NBANK-1:0] = fAssoc_reg;
            `CANRX_OFS_FACT: rdVal[NBANK-1:0] = fAct_reg;
            default: mapped = 1'b0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Queue bookkeeping.

   wire commit = rxDone & stgOn_reg & ~rxError;
   reg rel;
   reg full;
   reg store;
   reg [1:0] lvlR;
   reg [7:0] mapR;
   integer q;

   always @*
   begin
      rel = 1'b0;
      full = 1'b0;
      store = 1'b0;
      lvlR = 2'd0;
      mapR = 8'h00;
      for (q = 0; q < 2; q = q + 1)
      begin
         rel = apbWr && paddr == (q == 0 ? `CANRX_OFS_QCS0 : `CANRX_OFS_QCS1)
               && pwdata[`CANRX_QCS_REL] && lvl_reg[q] != 2'd0;
         lvlR = lvl_reg[q] - {1'b0, rel};
         mapR = rel ? mapRelease(map_reg[q]) : map_reg[q];
         full = lvlR == `CANRX_QDEPTH;
         store = commit && stgQ_reg == q
                 && !(full && ctl_reg[`CANRX_CTL_DROP]);
         // When full with CANRX_CTL_DROP clear, the new frame takes the newest position.
         map_next[q] = store ? mapCommit(mapR, full ? 2'd2 : lvlR) : mapR;
         lvl_next[q] = lvlR + {1'b0, store & ~full};
         // Set wins over the write-one-to-clear.
         ovr_next[q] = (commit && stgQ_reg == q && full)
                       || (ovr_reg[q] && !(apbWr && pwdata[`CANRX_QCS_OVR]
                       && paddr == (q == 0 ? `CANRX_OFS_QCS0 : `CANRX_OFS_QCS1)));
         if (rel)
            rdPtr_next[q] = 4'h0;
         else if (apbDone && !pwrite && qReg && qSel == q && qWord == 2'd2
                  && lvl_reg[q] != 2'd0)
            rdPtr_next[q] = rdPtr_reg[q] + 4'h1;
         else
            rdPtr_next[q] = rdPtr_reg[q];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frame storage writes.

   reg memWe;
   reg [7:0] memWaddr;
   reg [31:0] memWdata;
   wire [1:0] stgSlot = map_reg[stgQ_reg][7:6];

   always @*
   begin
      memWe = 1'b0;
      memWaddr = 8'h00;
      memWdata = `CANRX_RST_WORD;
      if (rxStart)
      begin
         memWe = hitAny;
         memWaddr = {hitQ, map_reg[hitQ][7:6], `CANRX_W_ID};
         memWdata = id32;
      end
      else if (rxWordValid)
      begin
         memWe = stgOn_reg && stgWord_reg < `CANRX_DATA_WORDS;
         memWaddr = {stgQ_reg, stgSlot, `CANRX_W_DATA + stgWord_reg};
         memWdata = rxWord;
      end
      else if (commit)
      begin
         memWe = 1'b1;
         memWaddr = {stgQ_reg, stgSlot, `CANRX_W_PROP};
         memWdata = {16'h0000, stgIdx_reg, 3'b000, stgFd_reg, stgDlc_reg};
      end
   end

   canrx_frame_mem #(
      .AW(8),
      .DW(32)
   )
   u_mem (
      .clk_sys(clk_sys),
      .memWe(memWe),
      .memWaddr(memWaddr),
      .memWdata(memWdata),
      .memRaddr({qSel, selMap[1:0], rdWord}),
      .memRdata(memRdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Registers.

   // Loop indices of their own, so that no variable has two driving processes.
   integer bi;
   integer qi;

   always @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         prdata <= `CANRX_RST_WORD;
         pready <= 1'b0;
         pslverr <= 1'b0;
         ctl_reg <= `CANRX_RST_WORD;
         fScale_reg <= `CANRX_RST_BANKS;
         fList_reg <= `CANRX_RST_BANKS;
         fAssoc_reg <= `CANRX_RST_BANKS;
         fAct_reg <= `CANRX_RST_BANKS;
         for (bi = 0; bi < NBANK; bi = bi + 1)
         begin
            fWord0_reg[bi] <= `CANRX_RST_WORD;
            fWord1_reg[bi] <= `CANRX_RST_WORD;
         end
         for (qi = 0; qi < 2; qi = qi + 1)
         begin
            map_reg[qi] <= `CANRX_RST_MAP;
            lvl_reg[qi] <= 2'd0;
            ovr_reg[qi] <= 1'b0;
            rdPtr_reg[qi] <= 4'h0;
         end
         stgOn_reg <= 1'b0;
         stgQ_reg <= 1'b0;
         stgIdx_reg <= 8'h00;
         stgDlc_reg <= 4'h0;
         stgFd_reg <= 1'b0;
         stgWord_reg <= 5'h00;
      end
      else
      begin
         // Every transfer takes one wait cycle so that storage reads settle.
         pready <= apbAccess & ~pready;
         pslverr <= apbAccess & ~pready & ~mapped;
         prdata <= (apbAccess & ~pready & ~pwrite) ? rdVal : `CANRX_RST_WORD;
         if (apbWr)
         begin
            if (fReg && !paddr[2])
               fWord0_reg[fBank] <= pwdata;
            if (fReg && paddr[2])
               fWord1_reg[fBank] <= pwdata;
            case (paddr)
               `CANRX_OFS_CTL: ctl_reg[`CANRX_CTL_DROP] <= pwdata[`CANRX_CTL_DROP];
               `CANRX_OFS_FSCALE: fScale_reg <= pwdata[NBANK-1:0];
               `CANRX_OFS_FLIST: fList_reg <= pwdata[NBANK-1:0];
               `CANRX_OFS_FASSOC: fAssoc_reg <= pwdata[NBANK-1:0];
               `CANRX_OFS_FACT: fAct_reg <= pwdata[NBANK-1:0];
               default: ctl_reg <= ctl_reg;
            endcase
         end
         for (qi = 0; qi < 2; qi = qi + 1)
         begin
            map_reg[qi] <= map_next[qi];
            lvl_reg[qi] <= lvl_next[qi];
            ovr_reg[qi] <= ovr_next[qi];
            rdPtr_reg[qi] <= rdPtr_next[qi];
         end
         // A frame that fails every filter never opens a staging slot.
         if (rxStart)
         begin
            stgOn_reg <= hitAny;
            stgQ_reg <= hitQ;
            stgIdx_reg <= hitNum;
            stgDlc_reg <= rxDlc;
            stgFd_reg <= rxFd;
            stgWord_reg <= 5'h00;
         end
         else if (rxError || rxDone)
            stgOn_reg <= 1'b0;
         else if (rxWordValid && stgOn_reg && stgWord_reg < `CANRX_DATA_WORDS)
            stgWord_reg <= stgWord_reg + 5'h01;
      end
   end

endmodule

// File: dv/canrx_filter_fifo_asserts.sv
// Concurrent checks on the APB ports of the CAN receive filter and queue block.
// Assumes one clock domain and the single wait state described for the slave.
`timescale 1ns/100ps
`include "canrx_consts.vh"

module canrx_filter_fifo_asserts #(
   parameter NBANK = 28
)
(
   // Clock and reset.
   input wire clk_sys,
   input wire rstn,
   // APB.
   input wire [11:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   wire qcsRead = pready && !pwrite
      && (paddr == `CANRX_OFS_QCS0 || paddr == `CANRX_OFS_QCS1);
   wire cfgRead = pready && !pwrite
      && paddr >= `CANRX_OFS_FSCALE && paddr <= `CANRX_OFS_FACT;

   ////////////////////////////////////////////////////////////////////////////
   a_ready_wait: assert property ($rose(psel && penable) |-> !pready ##1 pready)
      else $error("ready not in second access cycle");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   a_ready_access: assert property (pready |-> psel && penable && $past(psel && penable))
      else $error("ready outside an access phase");
   a_err_bare: assert property (pslverr |-> pready)
      else $error("error response without ready");
   a_misalign_err: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0)
      else $error("misaligned access not refused");
   a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer cycle");
   a_full_level: assert property (qcsRead && prdata[3] |-> prdata[1:0] == 2'h3)
      else $error("full flag with level below three");
   a_level_full: assert property (qcsRead && prdata[1:0] == 2'h3 |-> prdata[3])
      else $error("level three without full flag");
   a_bank_width: assert property (cfgRead |-> prdata[31:28] == 4'h0)
      else $error("bank field wider than bank count");
endmodule

bind canrx_filter_fifo canrx_filter_fifo_asserts #(.NBANK(NBANK)) chk (
   .clk_sys(clk_sys),
   .rstn(rstn),
   .paddr(paddr),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .prdata(prdata),
   .pready(pready),
   .pslverr(pslverr)
);

// File: dv/canrx_node_model.sv
// Far side of the receive path: a bit engine delivering frames from the bus.
// Assumes the start, word, done and error strobes are sampled at clk_sys edges.
`timescale 1ns/100ps

module canrx_node_model
(
   // Clock.
   input wire clk_sys,
   // Frame stream.
   output reg rxStart,
   output reg [10:0] rxStdId,
   output reg [17:0] rxExtId,
   output reg rxExtFmt,
   output reg rxRemote,
   output reg rxFd,
   output reg [3:0] rxDlc,
   output reg rxWordValid,
   output reg [31:0] rxWord,
   output reg rxDone,
   output reg rxError
);
   initial
   begin
      {rxStart, rxStdId, rxExtId, rxExtFmt, rxRemote, rxFd, rxDlc} = 37'h0;
      {rxWordValid, rxWord, rxDone, rxError} = 35'h0;
   end

   task automatic send(input [10:0] sid, input fd, input [3:0] dlc, input [4:0] nw,
      input [31:0] base, input bad);
      integer k;
      begin
         @(posedge clk_sys);
         rxStart <= 1'b1;
         rxStdId <= sid;
         rxExtId <= 18'h00000;
         rxExtFmt <= 1'b0;
         rxRemote <= 1'b0;
         rxFd <= fd;
         rxDlc <= dlc;
         for (k = 0; k < nw; k = k + 1)
         begin
            @(posedge clk_sys);
            rxStart <= 1'b0;
            rxWordValid <= 1'b1;
            rxWord <= base + k;
         end
         @(posedge clk_sys);
         rxStart <= 1'b0;
         rxWordValid <= 1'b0;
         // Header is scrambled once stale, so a late sample cannot pass.
         rxStdId <= ~sid;
         rxFd <= ~fd;
         rxDlc <= ~dlc;
         rxDone <= !bad;
         rxError <= bad;
         @(posedge clk_sys);
         rxDone <= 1'b0;
         rxError <= 1'b0;
         rxWord <= ~rxWord;
      end
   endtask
endmodule

// File: dv/canrx_tb.sv
// Self-checking bench for the CAN receive filter and queue block.
// Drives APB directly and frames through the node model.
`timescale 1ns/100ps
`include "canrx_consts.vh"

module tb;
   reg clk_sys = 1'b0;
   reg rstn = 1'b0;
   reg [11:0] paddr = 12'h000;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [31:0] pwdata = 32'h0;
   wire [31:0] prdata;
   wire pready, pslverr, rxStart, rxExtFmt, rxRemote, rxFd, rxWordValid, rxDone, rxError;
   wire [10:0] rxStdId;
   wire [17:0] rxExtId;
   wire [3:0] rxDlc;
   wire [31:0] rxWord;
   integer errors = 0;
   integer testsRun = 0;
   integer cycles = 0;
   reg [31:0] rd;
   reg rdErr;

   always #5 clk_sys = ~clk_sys;

   canrx_filter_fifo dut (.clk_sys(clk_sys), .rstn(rstn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rxStart(rxStart), .rxStdId(rxStdId), .rxExtId(rxExtId),
      .rxExtFmt(rxExtFmt), .rxRemote(rxRemote), .rxFd(rxFd), .rxDlc(rxDlc),
      .rxWordValid(rxWordValid), .rxWord(rxWord), .rxDone(rxDone), .rxError(rxError));
   canrx_node_model node (.clk_sys(clk_sys), .rxStart(rxStart), .rxStdId(rxStdId),
      .rxExtId(rxExtId), .rxExtFmt(rxExtFmt), .rxRemote(rxRemote), .rxFd(rxFd),
      .rxDlc(rxDlc), .rxWordValid(rxWordValid), .rxWord(rxWord), .rxDone(rxDone),
      .rxError(rxError));

   ////////////////////////////////////////////////////////////////////////////
   task tally_and_finish;
      begin
         if (errors == 0 && testsRun > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask

   task chk(input [31:0] got, input [31:0] exp);
      begin
         testsRun = testsRun + 1;
         if (got !== exp)
         begin
            errors = errors + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask

   // The wait lasts until the slave answers; only the cycle ceiling cuts it short.
   task apb(input wr, input [11:0] a, input [31:0] d);
      begin
         @(posedge clk_sys);
         psel <= 1'b1;
         pwrite <= wr;
         paddr <= a;
         pwdata <= d;
         @(posedge clk_sys);
         penable <= 1'b1;
         @(posedge clk_sys);
         while (pready !== 1'b1)
            @(posedge clk_sys);
         rd = prdata;
         rdErr = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task rdchk(input [11:0] a, input [31:0] exp);
      begin
         apb(1'b0, a, 32'h0);
         chk(rd, exp);
      end
   endtask

   task cfg(input [31:0] sc, input [31:0] ls, input [31:0] asc, input [31:0] act);
      begin
         apb(1'b1, `CANRX_OFS_FSCALE, sc);
         apb(1'b1, `CANRX_OFS_FLIST, ls);
         apb(1'b1, `CANRX_OFS_FASSOC, asc);
         apb(1'b1, `CANRX_OFS_FACT, act);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task t_reset_regs;
      begin
         rdchk(`CANRX_OFS_CTL, `CANRX_RST_WORD);
         rdchk(`CANRX_OFS_QCS1, 32'h0);
         rdchk(`CANRX_OFS_FACT, 32'h0);
         rdchk(`CANRX_OFS_Q0BASE, 32'h0);
         apb(1'b1, `CANRX_OFS_FSCALE, 32'hFFFFFFFF);
         rdchk(`CANRX_OFS_FSCALE, 32'h0FFFFFFF);
         apb(1'b1, 12'h1DC, 32'h5A5A5A5A);
         rdchk(12'h1DC, 32'h5A5A5A5A);
         apb(1'b0, 12'h1E0, 32'h0);
         chk({31'h0, rdErr}, 32'h1);
         apb(1'b0, 12'h102, 32'h0);
         chk({31'h0, rdErr}, 32'h1);
         apb(1'b0, 12'h022, 32'h0);
         chk({31'h0, rdErr}, 32'h1);
         chk(rd, 32'h0);
      end
   endtask

   task t_queue(input drop);
      integer k;
      integer s;
      begin
         cfg(32'h1, 32'h0, 32'h0, 32'h1);
         apb(1'b1, `CANRX_OFS_FBASE, 32'h0);
         apb(1'b1, `CANRX_OFS_FBASE + 12'h4, 32'h0);
         apb(1'b1, `CANRX_OFS_CTL, {31'h0, drop});
         for (k = 1; k <= 4; k = k + 1)
         begin
            node.send(k[10:0], 1'b0, 4'h8, 5'h02, {k[27:0], 4'h0}, 1'b0);
            if (k == 3)
               rdchk(`CANRX_OFS_QCS0, 32'hB);
         end
         rdchk(`CANRX_OFS_QCS0, 32'h1B);
         for (k = 0; k < 3; k = k + 1)
         begin
            s = (k == 2 && !drop) ? 4 : k + 1;
            rdchk(`CANRX_OFS_Q0BASE, {s[10:0], 21'h0});
            rdchk(`CANRX_OFS_Q0BASE + 12'h4, 32'h8);
            rdchk(`CANRX_OFS_Q0BASE + 12'hC, {s[27:0], 4'h1});
            rdchk(`CANRX_OFS_Q0BASE + 12'h8, {s[27:0], 4'h0});
            apb(1'b1, `CANRX_OFS_QCS0, 32'h20);
         end
         rdchk(`CANRX_OFS_QCS0, 32'h10);
         apb(1'b1, `CANRX_OFS_QCS0, 32'h10);
         rdchk(`CANRX_OFS_QCS0, 32'h0);
         rdchk(`CANRX_OFS_Q0BASE, 32'h0);
      end
   endtask

   task t_fd_error;
      integer k;
      begin
         node.send(11'h011, 1'b1, 4'hF, 5'h10, 32'h0, 1'b1);
         rdchk(`CANRX_OFS_QCS0, 32'h0);
         node.send(11'h011, 1'b1, 4'hF, 5'h10, 32'hA00, 1'b0);
         rdchk(`CANRX_OFS_QCS0, 32'h1);
         rdchk(`CANRX_OFS_Q0BASE + 12'h4, 32'h1F);
         for (k = 0; k < 16; k = k + 1)
            rdchk(`CANRX_OFS_Q0BASE + 12'h8, 32'hA00 + k);
         apb(1'b1, `CANRX_OFS_QCS0, 32'h20);
      end
   endtask

   task t_filters;
      begin
         cfg(32'h3, 32'h6, 32'hC, 32'hB);
         apb(1'b1, 12'h100, 32'h24600000);
         apb(1'b1, 12'h104, 32'hFFE00000);
         apb(1'b1, 12'h108, 32'h24600000);
         apb(1'b1, 12'h10C, 32'h0AA00000);
         apb(1'b1, 12'h110, 32'h00000EE0);
         apb(1'b1, 12'h114, 32'h0);
         apb(1'b1, 12'h118, 32'hFFFFFFE0);
         apb(1'b1, 12'h11C, 32'hFFE04000);
         node.send(11'h123, 1'b0, 4'h0, 5'h00, 32'h0, 1'b0);
         node.send(11'h055, 1'b0, 4'h0, 5'h00, 32'h0, 1'b0);
         node.send(11'h200, 1'b0, 4'h0, 5'h00, 32'h0, 1'b0);
         node.send(11'h077, 1'b0, 4'h0, 5'h00, 32'h0, 1'b0);
         node.send(11'h300, 1'b0, 4'h0, 5'h00, 32'h0, 1'b0);
         rdchk(`CANRX_OFS_QCS0, 32'h2);
         rdchk(`CANRX_OFS_QCS1, 32'h1);
         rdchk(`CANRX_OFS_Q0BASE + 12'h4, 32'h100);
         apb(1'b1, `CANRX_OFS_QCS0, 32'h20);
         rdchk(`CANRX_OFS_Q0BASE, 32'h0AA00000);
         rdchk(`CANRX_OFS_Q0BASE + 12'h4, 32'h200);
         rdchk(`CANRX_OFS_Q1BASE, 32'h40000000);
         rdchk(`CANRX_OFS_Q1BASE + 12'h4, 32'h500);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (4) @(posedge clk_sys);
      rstn <= 1'b1;
      t_reset_regs;
      t_queue(1'b1);
      t_queue(1'b0);
      t_fd_error;
      t_filters;
      tally_and_finish;
   end

   // About five hundred cycles are expected; the ceiling leaves ample slack.
   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         errors = errors + 1;
         tally_and_finish;
      end
   end
endmodule
